// file: src/qbt_odd_parity.sv
// Module: parity tree over one word.
// Assumes: purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none

module qbt_odd_parity #(
  parameter int WIDTH = qbt_pkg::QBT_WORD_W
) (
  input wire logic [WIDTH-1:0] data,
  output logic parity
);

  // ==========================================================
  // Exclusive-or of all bits
  assign parity = ^data;

endmodule

`default_nettype wire

// file: src/qbt_pkg.sv
// Package: shared constants and types of the quad bus transceiver.
// Assumes: included before every design file that names qbt_pkg.
package qbt_pkg;

  // ==========================================================
  // Word shape
  localparam int QBT_WORD_W = 4;
  localparam int QBT_BUF_DEPTH = 2;

  // ==========================================================
  // Levels and reset values
  localparam logic QBT_DRV_CLK_PREV_RST = 1'b1;
  localparam logic QBT_PARITY_RST = 1'b0;
  localparam logic QBT_PULSE_RST = 1'b0;
  localparam logic QBT_LOADED_RST = 1'b0;
  localparam logic QBT_BUS_PULL_LEVEL = 1'b0;

  // ==========================================================
  // Receiver latch state
  typedef enum logic [0:0] {
    QBT_LATCH_OPEN = 1'b0,
    QBT_LATCH_HELD = 1'b1
  } qbt_latch_state_t;

endpackage

// file: src/qbt_transceiver.sv
// What this block does
// - Driver clock rising edge loads four-bit register
// - Drive enable high: bus drivers not driving
// - Enabled bus line is inverse of register
// - Drivers only pull low, wired-OR bus
// - Receiver presents inverse of each bus line
// - Latch enable low: latches follow inverted bus
// - Latch enable high: hold value, ignore bus
// - Output enable high: receiver outputs undriven
// - Drivers enabled: parity of driver input word
// - Drivers disabled: parity of latched receive word
//
// File: top of the quad bus transceiver with parity.
// Assumes: all pins synchronous to clk; the bus wire is resolved outside
// from bus_oe (pull low) and bus_out; receiver three-state resolved outside.
`timescale 1ns/1ps
`default_nettype none

module qbt_transceiver #(
  parameter int WIDTH = qbt_pkg::QBT_WORD_W,
  parameter int BUF_DEPTH = qbt_pkg::QBT_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic driver_reg_clock,
  input wire logic bus_drive_enable_n,
  input wire logic [WIDTH-1:0] bus_in,
  output logic [WIDTH-1:0] bus_out,
  output logic [WIDTH-1:0] bus_oe,
  input wire logic receive_latch_enable,
  input wire logic rx_out_enable_n,
  output logic [WIDTH-1:0] rx_data,
  output logic rx_oe,
  output logic rx_word_valid,
  output logic parity_odd,
  output logic driver_loaded
);

  // ==========================================================
  // Declarations
  logic [WIDTH-1:0] head_data;
  logic head_valid;
  logic head_ready;

  logic drv_clk_prev_reg, drv_clk_prev_next;
  logic drv_edge;
  logic [WIDTH-1:0] drv_word_reg, drv_word_next;
  logic loaded_reg, loaded_next;

  qbt_pkg::qbt_latch_state_t latch_state_reg, latch_state_next;
  logic [WIDTH-1:0] rx_latch_reg, rx_latch_next;
  logic [WIDTH-1:0] rx_inverted;
  logic rx_valid_reg, rx_valid_next;

  logic par_gen;
  logic par_chk;
  logic parity_reg, parity_next;

  // ==========================================================
  // Input word buffer
  // A word waits here until a driver clock edge takes it, so a
  // source that runs ahead is stalled through in_ready, not lost.
  qbt_word_buf #(
    .WIDTH(WIDTH),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(in_data),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(head_data),
    .out_valid(head_valid),
    .out_ready(head_ready)
  );

  // ==========================================================
  // Driver clock edge detection
  assign drv_edge = driver_reg_clock && !drv_clk_prev_reg;
  assign head_ready = drv_edge;

  always_comb begin
    drv_clk_prev_next = driver_reg_clock;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      drv_clk_prev_reg <= qbt_pkg::QBT_DRV_CLK_PREV_RST;
    end else begin
      drv_clk_prev_reg <= drv_clk_prev_next;
    end
  end

  // ==========================================================
  // Driver register
  // All four bits load together from the buffer head on the edge;
  // an edge with an empty buffer keeps the old word.
  always_comb begin
    drv_word_next = drv_word_reg;
    if (drv_edge && head_valid) begin
      drv_word_next = head_data;
    end
  end

  // Data flops carry no reset
  always_ff @(posedge clk) begin
    drv_word_reg <= drv_word_next;
  end

  // Marks that the register holds a defined word
  always_comb begin
    loaded_next = loaded_reg;
    if (drv_edge && head_valid) begin
      loaded_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      loaded_reg <= qbt_pkg::QBT_LOADED_RST;
    end else begin
      loaded_reg <= loaded_next;
    end
  end

  assign driver_loaded = loaded_reg;

  // ==========================================================
  // Open-collector bus drivers
  // A register one becomes a pulled-low line; a zero releases it.
  // The driven level is only ever low, so other devices can share
  // each line as a wired-OR.
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bus_bit
      assign bus_out[gi] = qbt_pkg::QBT_BUS_PULL_LEVEL;
      assign bus_oe[gi] = !bus_drive_enable_n && drv_word_reg[gi];
      assign rx_inverted[gi] = !bus_in[gi];
    end
  endgenerate

  // ==========================================================
  // Receiver latch state
  always_comb begin
    if (receive_latch_enable) begin
      latch_state_next = qbt_pkg::QBT_LATCH_HELD;
    end else begin
      latch_state_next = qbt_pkg::QBT_LATCH_OPEN;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      latch_state_reg <= qbt_pkg::QBT_LATCH_OPEN;
    end else begin
      latch_state_reg <= latch_state_next;
    end
  end

  // ==========================================================
  // Receiver latches
  // Open: follow the inverted bus each cycle. Closed: the word seen
  // in the last open cycle stays regardless of the bus.
  always_comb begin
    rx_latch_next = rx_latch_reg;
    if (!receive_latch_enable) begin
      rx_latch_next = rx_inverted;
    end else begin
      rx_latch_next = rx_latch_reg;
    end
  end

  // Data flops carry no reset
  always_ff @(posedge clk) begin
    rx_latch_reg <= rx_latch_next;
  end

  // ==========================================================
  // Closing pulse
  // On the edge the latch closes, flags for one cycle that a word is held.
  always_comb begin
    rx_valid_next = qbt_pkg::QBT_PULSE_RST;
    case (latch_state_reg)
      qbt_pkg::QBT_LATCH_OPEN: begin
        rx_valid_next = receive_latch_enable;
      end
      qbt_pkg::QBT_LATCH_HELD: begin
        rx_valid_next = 1'b0;
      end
      default: begin
        rx_valid_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_valid_reg <= qbt_pkg::QBT_PULSE_RST;
    end else begin
      rx_valid_reg <= rx_valid_next;
    end
  end

  assign rx_word_valid = rx_valid_reg;

  // ==========================================================
  // Three-state receiver outputs
  assign rx_data = rx_latch_reg;
  assign rx_oe = !rx_out_enable_n;

  // ==========================================================
  // Parity generate / check
  qbt_odd_parity #(
    .WIDTH(WIDTH)
  ) u_par_gen (
    .data(head_data),
    .parity(par_gen)
  );

  qbt_odd_parity #(
    .WIDTH(WIDTH)
  ) u_par_chk (
    .data(rx_latch_reg),
    .parity(par_chk)
  );

  // Drive enable selects which word the parity output covers
  always_comb begin
    if (!bus_drive_enable_n) begin
      parity_next = par_gen;
    end else begin
      parity_next = par_chk;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      parity_reg <= qbt_pkg::QBT_PARITY_RST;
    end else begin
      parity_reg <= parity_next;
    end
  end

  assign parity_odd = parity_reg;

endmodule

`default_nettype wire

// file: src/qbt_word_buf.sv
// Module: two-entry word buffer with valid/ready on both sides.
// Assumes: one clock, synchronous active-low reset; storage in flip-flops.
`timescale 1ns/1ps
`default_nettype none

module qbt_word_buf #(
  parameter int WIDTH = qbt_pkg::QBT_WORD_W,
  parameter int DEPTH = qbt_pkg::QBT_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST_IDX = PTR_W'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next;
  logic [PTR_W-1:0] rd_ptr_reg, rd_ptr_next;
  logic [CNT_W-1:0] count_reg, count_next;
  logic push, pop;

  // ==========================================================
  // Handshake
  assign in_ready = (count_reg != CNT_W'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_reg[rd_ptr_reg];

  // ==========================================================
  // Pointers and fill level
  always_comb begin
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == LAST_IDX) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == LAST_IDX) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

  // ==========================================================
  // Storage, no reset
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

endmodule

`default_nettype wire

// file: tb/qbt_bus_partner.sv
// Model: shared wired-OR bus lines with pull-up.
// Assumes: far_pull bits come from the bench as other bus devices.
`timescale 1ns/1ps
`default_nettype none

module qbt_bus_partner #(
  parameter int WIDTH = 4
) (
  input wire logic [WIDTH-1:0] bus_out,
  input wire logic [WIDTH-1:0] bus_oe,
  input wire logic [WIDTH-1:0] far_pull,
  output logic [WIDTH-1:0] bus_line
);
  // ==========
  // Idle lines float high; any puller wins low
  assign bus_line = ((bus_oe & bus_out) | ~bus_oe) & ~far_pull;
endmodule

`default_nettype wire

// file: tb/qbt_monitor.sv
// Checker: port-level properties of the transceiver top.
// Assumes: bound to qbt_transceiver; one clock domain.
`timescale 1ns/1ps
`default_nettype none

module qbt_monitor #(
  parameter int WIDTH = 4,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic driver_reg_clock,
  input wire logic bus_drive_enable_n,
  input wire logic [WIDTH-1:0] bus_in,
  input wire logic [WIDTH-1:0] bus_out,
  input wire logic [WIDTH-1:0] bus_oe,
  input wire logic receive_latch_enable,
  input wire logic rx_out_enable_n,
  input wire logic [WIDTH-1:0] rx_data,
  input wire logic rx_oe,
  input wire logic rx_word_valid,
  input wire logic parity_odd,
  input wire logic driver_loaded
);
  // ==========
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_bus_off; bus_drive_enable_n |-> bus_oe == '0; endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus pulled while disabled");
  property p_pull_low; bus_out == '0; endproperty
  a_pull_low: assert property (p_pull_low) else $error("bus driven high");
  property p_rx_oe; rx_oe == !rx_out_enable_n; endproperty
  a_rx_oe: assert property (p_rx_oe) else $error("receiver enable wrong");
  property p_follow; !receive_latch_enable |=> rx_data == ~$past(bus_in); endproperty
  a_follow: assert property (p_follow) else $error("latch not following bus");
  property p_hold; receive_latch_enable |=> $stable(rx_data); endproperty
  a_hold: assert property (p_hold) else $error("closed latch changed");
  property p_closed; $rose(receive_latch_enable) |=> rx_word_valid ##1 !rx_word_valid; endproperty
  a_closed: assert property (p_closed) else $error("close pulse wrong");
  property p_no_edge;
    $past(rst_b) && (!$past(driver_reg_clock) || $past(driver_reg_clock, 2))
      && $stable(bus_drive_enable_n) |-> $stable(bus_oe);
  endproperty
  a_no_edge: assert property (p_no_edge) else $error("driver changed without edge");
  property p_par_chk;
    $past(rst_b) && $past(rst_b, 2) && $past(bus_drive_enable_n) |-> parity_odd == ^$past(rx_data);
  endproperty
  a_par_chk: assert property (p_par_chk) else $error("check parity wrong");
endmodule

bind qbt_transceiver qbt_monitor #(.WIDTH(WIDTH), .BUF_DEPTH(BUF_DEPTH)) u_mon (.*);

`default_nettype wire

// file: tb/qbt_transceiver_tb.sv
// Bench: directed scenarios for the quad bus transceiver.
// Assumes: design sources and the bus partner model compiled first.
`timescale 1ns/1ps
`default_nettype none

module qbt_transceiver_tb;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] in_data = 4'h0;
  logic in_valid = 1'b0;
  logic driver_reg_clock = 1'b0;
  logic bus_drive_enable_n = 1'b1;
  logic receive_latch_enable = 1'b0;
  logic rx_out_enable_n = 1'b0;
  logic [3:0] far_pull = 4'h0;
  logic [3:0] bus_line, bus_out, bus_oe, rx_data;
  logic in_ready, rx_oe, rx_word_valid, parity_odd, driver_loaded;
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  qbt_transceiver u_dut (
    .clk(clk), .rst_b(rst_b), .in_data(in_data), .in_valid(in_valid), .in_ready(in_ready),
    .driver_reg_clock(driver_reg_clock), .bus_drive_enable_n(bus_drive_enable_n),
    .bus_in(bus_line), .bus_out(bus_out), .bus_oe(bus_oe),
    .receive_latch_enable(receive_latch_enable), .rx_out_enable_n(rx_out_enable_n),
    .rx_data(rx_data), .rx_oe(rx_oe), .rx_word_valid(rx_word_valid),
    .parity_odd(parity_odd), .driver_loaded(driver_loaded)
  );
  qbt_bus_partner u_bus (.bus_out(bus_out), .bus_oe(bus_oe), .far_pull(far_pull), .bus_line(bus_line));

  // ==========
  // Helpers
  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic drv_edge;
    driver_reg_clock = 1'b1;
    tick(1);
    driver_reg_clock = 1'b0;
    tick(1);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========
  // Scenarios
  task automatic t_drive;
    chk("in_ready", in_ready, 4'h1);
    chk("not loaded", driver_loaded, 4'h0);
    in_data = 4'h7;
    in_valid = 1'b1;
    tick(1);
    in_data = 4'ha;
    tick(1);
    in_data = 4'h3;
    tick(1);
    in_valid = 1'b0;
    chk("in_ready full", in_ready, 4'h0);
    drv_edge;
    chk("loaded", driver_loaded, 4'h1);
    chk("bus_oe off", bus_oe, 4'h0);
    chk("in_ready", in_ready, 4'h1);
    bus_drive_enable_n = 1'b0;
    tick(1);
    chk("bus 7", bus_line, ~4'h7);
    chk("parity gen a", parity_odd, 4'h0);
    drv_edge;
    chk("bus a", bus_line, ~4'ha);
    in_data = 4'hb;
    in_valid = 1'b1;
    tick(1);
    in_valid = 1'b0;
    tick(1);
    chk("parity gen b", parity_odd, 4'h1);
    drv_edge;
    chk("bus b", bus_line, ~4'hb);
    drv_edge;
    chk("bus keep", bus_line, ~4'hb);
    far_pull = 4'h4;
    tick(1);
    chk("wired or", bus_line, 4'h0);
  endtask

  task automatic t_rx;
    chk("rx follow", rx_data, 4'hf);
    bus_drive_enable_n = 1'b1;
    far_pull = 4'h1;
    tick(1);
    chk("rx open", rx_data, 4'h1);
    receive_latch_enable = 1'b1;
    tick(1);
    chk("close pulse", rx_word_valid, 4'h1);
    chk("parity chk 1", parity_odd, 4'h1);
    far_pull = 4'h6;
    tick(1);
    chk("pulse end", rx_word_valid, 4'h0);
    chk("rx held", rx_data, 4'h1);
    rx_out_enable_n = 1'b1;
    #1;
    chk("rx_oe off", rx_oe, 4'h0);
    rx_out_enable_n = 1'b0;
    #1;
    chk("rx_oe on", rx_oe, 4'h1);
    receive_latch_enable = 1'b0;
    tick(2);
    chk("rx reopen", rx_data, 4'h6);
    chk("parity chk 6", parity_odd, 4'h0);
  endtask

  // ==========
  // Run and watchdog
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  initial begin
    tick(16);
    rst_b = 1'b1;
    tick(1);
    t_drive;
    t_rx;
    tally_and_finish;
  end
endmodule

`default_nettype wire
